// ==== verilog/tws_slave.sv ====
// Two-wire slave port with bus event reporting and an AHB-Lite register slave
//
// Operation
// R1 - Address match with write direction clears direction bit, loads buffer
// R2 - No address acknowledge while buffer full or overflow is set
// R3 - Every data byte sets the port flag; software clears it
// R4 - Read address match sets direction, loads buffer, acks, then holds SCL
// R5 - Software loads transmit byte, then sets clock release to free SCL
// R6 - Master must check SCL before each clock pulse; slave may stretch
// R7 - Transmit bits change on SCL falling edges
// R8 - Port flag set on falling edge of the ninth pulse
// R9 - Master acknowledge latched on ninth rise; high ends transfer
// R10 - After master ack, software loads next byte and releases clock
// R11 - Data byte loads buffer and acks only if buffer free, no overflow
// R12 - Start and stop bits clear on reset or disable, follow bus
// R13 - Firmware master claims bus only after stop or when bus idle
// R14 - Cleared direction bit drives its line low
// R15 - Port flag set on start, stop and each finished byte; start and stop set it only in modes 1011, 1110 and 1111
// R16 - Mode 1011 is firmware master with slave idle
// R17 - Enabled port interrupt fires on the next stop of a busy bus
// R18 - Multi-master firmware releases both lines on lost arbitration
// R19 - Slave keeps receiving after lost arbitration and acks if addressed
// R20 - Software keeps sample phase and edge select bits clear
// R21 - Address compared on falling edge of eighth pulse
// R22 - Incoming bits sampled on SCL rising edge
// R23 - Buffer read clears buffer full; overflow cleared by software
// R24 - Ten-bit: address write clears update flag and releases SCL
// R25 - Start is SDA fall with SCL high; stop is SDA rise
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
module tws_slave (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [tws_pkg::AW-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [tws_pkg::DW-1:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [tws_pkg::DW-1:0] hrdata,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   import tws_pkg::*;

   logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   logic wr_pend;
   logic [7:0] wr_idx;
   logic [7:0] int_global, irq_flags, irq_enables, direction;
   logic [7:0] buffer, addr_match, control, shifter;
   logic [7:0] status;
   logic buf_full, rw_dir, addr_upd, data_addr, halt_seen, begin_seen;
   logic [1:0] stat_sw;
   tws_state_t state;
   logic [3:0] bit_cnt;
   logic rx_addr, next_send, ack_drv, master_nack, tx_hold;
   logic ten_lo, ten_done;

   // ---------------------------------------------------------------
   // Pin synchronisers and bus conditions
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
      end
   end

   wire scl_rise = scl_s2 & ~scl_d;
   wire scl_fall = ~scl_s2 & scl_d;
   wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2; // R25
   wire stop_det = scl_s2 & scl_d & ~sda_d & sda_s2; // R25

   // ---------------------------------------------------------------
   // Mode decode and byte events
   // ---------------------------------------------------------------
   wire [3:0] mode = control[3:0];
   wire enabled = control[CTL_ENABLE];
   wire ten = (mode == MODE_SLV10) | (mode == MODE_SLV10_EVT);
   // Firmware master mode leaves the slave idle
   wire slave_on = enabled & (mode == MODE_SLV7 | ten |
      mode == MODE_SLV7_EVT); // R16
   wire edge_irq = enabled & (mode == MODE_FW_MASTER |
      mode == MODE_SLV7_EVT | mode == MODE_SLV10_EVT); // R16
   wire rx_ok = ~buf_full & ~control[CTL_OVERFLOW]; // R2 R11
   wire decide = (state == S_RECV) & scl_fall & (bit_cnt == BYTE_BITS);
   wire match = ten_lo ? (shifter == addr_match) :
      (shifter[7:1] == addr_match[7:1] &
      (~ten | ~shifter[0] | ten_done)); // R21
   wire acc_addr = decide & rx_addr & slave_on & match & rx_ok; // R2 R19
   wire acc_data = decide & ~rx_addr & rx_ok; // R11
   wire ovf_data = decide & ~rx_addr & buf_full; // R11
   wire load_buf = acc_addr | acc_data;
   wire dir_byte = acc_addr & ~(ten & ten_lo);
   wire is_read = dir_byte & shifter[0];
   wire ack_end = (state == S_ACK) & scl_fall;
   wire mack_end = (state == S_MACK) & scl_fall;
   wire nack_end = mack_end & master_nack; // R9
   wire stretch = (ack_end & next_send) | (mack_end & ~master_nack);
   wire port_evt = ack_end | mack_end |
      (edge_irq & (start_det | stop_det)); // R8 R15 R17

   // ---------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ---------------------------------------------------------------
   wire take = hsel & htrans[1] & hready;
   wire [7:0] a_idx = haddr[9:2];
   wire a_ok = (haddr[31:10] == ADDR_HI_ZERO) & (haddr[1:0] == 2'h0);
   wire rd_buf = take & ~hwrite & a_ok & (a_idx == IDX_BUFFER);
   wire wr_buf = wr_pend & (wr_idx == IDX_BUFFER);
   wire wr_ctl = wr_pend & (wr_idx == IDX_CONTROL);
   wire wr_adr = wr_pend & (wr_idx == IDX_ADDR_MATCH);
   wire [7:0] wd = hwdata[7:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx <= RST_ZERO;
      end else begin
         wr_pend <= take & hwrite & a_ok;
         wr_idx <= a_idx;
      end
   end

   // Read data is registered in the address phase; unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= {RD_PAD, RST_ZERO};
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (take & ~hwrite) begin
         unique case (a_idx & {8{a_ok}})
            IDX_INT_GLOBAL: hrdata <= {RD_PAD, int_global};
            IDX_IRQ_FLAGS: hrdata <= {RD_PAD, irq_flags};
            IDX_BUFFER: hrdata <= {RD_PAD, buffer};
            IDX_CONTROL: hrdata <= {RD_PAD, control};
            IDX_DIRECTION: hrdata <= {RD_PAD, direction};
            IDX_IRQ_ENABLES: hrdata <= {RD_PAD, irq_enables};
            IDX_ADDR_MATCH: hrdata <= {RD_PAD, addr_match};
            IDX_STATUS: hrdata <= {RD_PAD, status};
            default: hrdata <= {RD_PAD, RST_ZERO};
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Plain software registers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_global <= RST_ZERO;
         irq_enables <= RST_ZERO;
         direction <= RST_DIRECTION;
         addr_match <= RST_ZERO;
      end else if (wr_pend) begin
         if (wr_idx == IDX_INT_GLOBAL)
            int_global <= wd;
         if (wr_idx == IDX_IRQ_ENABLES)
            irq_enables <= wd & MASK_IRQ;
         if (wr_idx == IDX_DIRECTION)
            direction <= wd;
         if (wr_adr)
            addr_match <= wd;
      end
   end

   // Hardware sets the port flag; a set in the cycle of a clear wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_flags <= RST_ZERO;
      end else begin
         if (wr_pend & (wr_idx == IDX_IRQ_FLAGS))
            irq_flags <= wd & MASK_IRQ; // R3
         if (port_evt)
            irq_flags[IRQ_PORT] <= 1'b1; // R3 R15
      end
   end

   // ---------------------------------------------------------------
   // Control: overflow and collision are sticky, clock release drops
   // when the slave starts to stretch
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control <= RST_ZERO;
      end else begin
         if (wr_ctl)
            control <= wd; // R5 R23
         if (stretch)
            control[CTL_CLK_REL] <= 1'b0; // R4
         if (ovf_data)
            control[CTL_OVERFLOW] <= 1'b1;
         if (wr_buf & (state == S_SEND) & (bit_cnt != 4'h0))
            control[CTL_COLLIDE] <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Buffer
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         buffer <= RST_ZERO;
      end else if (load_buf) begin
         buffer <= shifter; // R1 R4 R11
      end else if (wr_buf) begin
         buffer <= wd;
      end
   end

   // ---------------------------------------------------------------
   // Status
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         buf_full <= 1'b0;
         addr_upd <= 1'b0;
         stat_sw <= 2'h0;
      end else begin
         if (rd_buf)
            buf_full <= 1'b0; // R23
         if (load_buf)
            buf_full <= 1'b1;
         if (wr_adr)
            addr_upd <= 1'b0; // R24
         if (acc_addr & ten & ~is_read)
            addr_upd <= 1'b1;
         if (wr_pend & (wr_idx == IDX_STATUS))
            stat_sw <= wd[7:6]; // R20
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rw_dir <= 1'b0;
         data_addr <= 1'b0;
      end else if (nack_end | ~enabled) begin
         rw_dir <= 1'b0; // R9
         data_addr <= 1'b0;
      end else begin
         if (dir_byte)
            rw_dir <= shifter[0]; // R1 R4
         if (acc_addr)
            data_addr <= 1'b0;
         if (acc_data)
            data_addr <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         halt_seen <= 1'b0;
         begin_seen <= 1'b0;
      end else if (!enabled) begin
         halt_seen <= 1'b0; // R12
         begin_seen <= 1'b0;
      end else if (start_det) begin
         begin_seen <= 1'b1; // R12
         halt_seen <= 1'b0;
      end else if (stop_det) begin
         halt_seen <= 1'b1; // R12
         begin_seen <= 1'b0;
      end
   end

   assign status = {stat_sw, data_addr, halt_seen, begin_seen, rw_dir,
      addr_upd, buf_full};

   // ---------------------------------------------------------------
   // Byte engine
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         shifter <= RST_ZERO;
         rx_addr <= 1'b0;
         next_send <= 1'b0;
         ack_drv <= 1'b0;
         master_nack <= 1'b0;
      end else if (!slave_on) begin
         state <= S_IDLE;
         ack_drv <= 1'b0;
      end else if (start_det) begin
         // The slave listens even while firmware drives the lines
         state <= S_RECV; // R19
         bit_cnt <= 4'h0;
         rx_addr <= 1'b1;
         ack_drv <= 1'b0;
      end else if (stop_det) begin
         state <= S_IDLE;
         ack_drv <= 1'b0;
      end else begin
         if (wr_buf & (state != S_RECV))
            shifter <= wd; // R5
         unique case (state)
            S_IDLE: begin
               bit_cnt <= 4'h0;
            end
            S_RECV: begin
               if (scl_rise) begin
                  shifter <= {shifter[6:0], sda_s2}; // R22
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (decide) begin
                  ack_drv <= load_buf; // R2 R11
                  next_send <= is_read;
                  state <= (rx_addr & ~acc_addr) ? S_IDLE : S_ACK;
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  ack_drv <= 1'b0;
                  bit_cnt <= 4'h0;
                  rx_addr <= ten & ten_lo;
                  state <= next_send ? S_SEND : S_RECV;
               end
            end
            S_SEND: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt == BYTE_BITS)
                     state <= S_MACK;
                  else
                     shifter <= {shifter[6:0], 1'b1}; // R7
               end
            end
            S_MACK: begin
               if (scl_rise) begin
                  master_nack <= sda_s2; // R9
               end else if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  state <= master_nack ? S_IDLE : S_SEND; // R9
               end
            end
         endcase
      end
   end

   // Ten-bit address progress; a stop forgets a partial match
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ten_lo <= 1'b0;
         ten_done <= 1'b0;
      end else if (!slave_on | stop_det) begin
         ten_lo <= 1'b0;
         ten_done <= 1'b0;
      end else if (acc_addr & ten & ~is_read) begin
         ten_lo <= ~ten_lo;
         ten_done <= ten_lo;
      end else if (decide & rx_addr & ~acc_addr) begin
         ten_lo <= 1'b0;
      end
   end

   // SCL is stretched until software sets clock release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_hold <= 1'b0;
      end else if (stretch) begin
         tx_hold <= 1'b1; // R4
      end else if (control[CTL_CLK_REL] | ~slave_on | stop_det) begin
         tx_hold <= 1'b0; // R5
      end
   end

   // ---------------------------------------------------------------
   // Open-drain pins: enable high pulls the line low
   // ---------------------------------------------------------------
   wire hold_scl = slave_on & ((tx_hold & ~control[CTL_CLK_REL]) |
      (addr_upd & ten & (state != S_ACK))); // R4 R24
   wire pull_sda = slave_on & (ack_drv |
      ((state == S_SEND) & ~shifter[7])); // R7

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         scl_oe <= hold_scl | ~direction[DIR_SCL]; // R14
         sda_oe <= pull_sda | ~direction[DIR_SDA]; // R14
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   start_flag_a: assert property ( // R25
      enabled & start_det |=> begin_seen & ~halt_seen)
      else $error("start condition not recorded");
   disable_clr_a: assert property ( // R12
      ~enabled |=> ~begin_seen & ~halt_seen)
      else $error("start or stop bit survived disable");
   addr_refuse_a: assert property ( // R2
      decide & rx_addr & ~rx_ok |=> ~ack_drv ##1 ~sda_oe | ~$past(pull_sda))
      else $error("address acknowledged with buffer busy");
   rx_load_a: assert property ( // R1
      acc_addr & ~shifter[0] & ~ten |=> buffer == $past(shifter) & ~rw_dir)
      else $error("write address not loaded");
   full_keep_a: assert property ( // R11
      ovf_data |=> buffer == $past(buffer) & control[CTL_OVERFLOW])
      else $error("full buffer was overwritten");
   ninth_flag_a: assert property ( // R8
      ack_end |=> irq_flags[IRQ_PORT])
      else $error("port flag missed on ninth pulse");
   stop_flag_a: assert property ( // R17
      edge_irq & stop_det |=> irq_flags[IRQ_PORT] & halt_seen)
      else $error("stop did not raise the port flag");
   nack_end_a: assert property ( // R9
      nack_end |=> state == S_IDLE & ~rw_dir)
      else $error("transfer not ended on master nack");
   read_hold_a: assert property ( // R4
      ack_end & next_send & slave_on & ~stop_det |=> ##1 scl_oe)
      else $error("SCL not held after read address");
   buf_read_a: assert property ( // R23
      rd_buf & ~load_buf |=> ~buf_full & hrdata[7:0] == $past(buffer))
      else $error("buffer read did not clear full flag");
   dir_drive_a: assert property ( // R14
      ~direction[DIR_SDA] |=> sda_oe)
      else $error("cleared direction bit did not drive SDA");
   okay_resp_a: assert property (##1 ~hresp & hreadyout)
      else $error("bus response not OKAY");

   cov_read_c: cover property (acc_addr & is_read ##[1:1000] mack_end);
   cov_write_c: cover property (acc_data);
   cov_ovf_c: cover property (ovf_data);
   cov_stop_c: cover property (edge_irq & stop_det);
endmodule

// ==== verilog/tws_pkg.sv ====
// Register map, field positions, modes and states of the two-wire slave
package tws_pkg;
   localparam int AW = 32;
   localparam int DW = 32;
   // ---------------------------------------------------------------
   // Register indexes (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_INT_GLOBAL = 8'h0b;
   localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
   localparam logic [7:0] IDX_BUFFER = 8'h13;
   localparam logic [7:0] IDX_CONTROL = 8'h14;
   localparam logic [7:0] IDX_DIRECTION = 8'h86;
   localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
   localparam logic [7:0] IDX_ADDR_MATCH = 8'h93;
   localparam logic [7:0] IDX_STATUS = 8'h94;
   // ---------------------------------------------------------------
   // Reset values and masks
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'hff;
   localparam logic [7:0] MASK_IRQ = 8'h4f;
   localparam logic [7:0] MASK_STAT_SW = 8'hc0;
   localparam logic [21:0] ADDR_HI_ZERO = 22'h000000;
   localparam logic [23:0] RD_PAD = 24'h000000;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTL_COLLIDE = 7;
   localparam int CTL_OVERFLOW = 6;
   localparam int CTL_ENABLE = 5;
   localparam int CTL_CLK_REL = 4;
   localparam int ST_DATA_ADDR = 5;
   localparam int ST_HALT = 4;
   localparam int ST_BEGIN = 3;
   localparam int ST_RW_DIR = 2;
   localparam int ST_ADDR_UPD = 1;
   localparam int ST_BUF_FULL = 0;
   localparam int IRQ_PORT = 3;
   localparam int DIR_SCL = 4;
   localparam int DIR_SDA = 1;
   // ---------------------------------------------------------------
   // Modes, counts and states
   // ---------------------------------------------------------------
   localparam logic [3:0] MODE_SLV7 = 4'h6;
   localparam logic [3:0] MODE_SLV10 = 4'h7;
   localparam logic [3:0] MODE_FW_MASTER = 4'hb;
   localparam logic [3:0] MODE_SLV7_EVT = 4'he;
   localparam logic [3:0] MODE_SLV10_EVT = 4'hf;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   typedef enum logic [2:0] {
      S_IDLE, S_RECV, S_ACK, S_SEND, S_MACK
   } tws_state_t;
endpackage

// ==== tb/tws_i2c_master.sv ====
// Behavioural two-wire bus master driving the slave under test
`timescale 1ns/100ps
module tws_i2c_master (
   input wire logic scl,
   input wire logic sda,
   output logic scl_low,
   output logic sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // ---------------------------------------------------------------
   // Bit timing, 48 ns low and 16 ns high
   // ---------------------------------------------------------------
   // Long low phase leaves room for the slave's synchroniser delay
   task automatic bit_io(input logic b, output logic r);
      #16 sda_low = !b;
      #32 scl_low = 1'b0;
      wait (scl === 1'b1);
      #16 r = sda;
      scl_low = 1'b1;
   endtask
   task automatic start();
      #16 sda_low = 1'b1;
      #32 scl_low = 1'b1;
   endtask
   task automatic stop();
      #16 sda_low = 1'b1;
      #32 scl_low = 1'b0;
      wait (scl === 1'b1);
      #16 sda_low = 1'b0;
      #32;
   endtask
   task automatic byte_io(input logic [7:0] d, input logic a,
         output logic [7:0] q, output logic k);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q = {q[6:0], r};
      end
      bit_io(a, k);
   endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the two-wire slave: registers, receive, transmit
`timescale 1ns/100ps
module tb;
   import tws_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [AW-1:0] haddr = '0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [DW-1:0] hwdata = '0;
   logic hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe;
   logic [DW-1:0] hrdata;
   logic m_scl_low, m_sda_low, k;
   logic [7:0] q, rd;
   logic [7:0] regs [9] = '{IDX_INT_GLOBAL, IDX_IRQ_FLAGS, IDX_BUFFER,
      IDX_CONTROL, IDX_DIRECTION, IDX_IRQ_ENABLES, IDX_ADDR_MATCH,
      IDX_STATUS, 8'h01};
   int num_errors = 0;
   int cmp_count = 0;
   // Open-drain wires with pull-ups
   wire scl = (scl_oe ? scl_out : 1'b1) & !m_scl_low;
   wire sda = (sda_oe ? sda_out : 1'b1) & !m_sda_low;
   always #4 hclk = !hclk;
   tws_slave u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .scl_in(scl), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
   tws_i2c_master u_mst (.scl(scl), .sda(sda), .scl_low(m_scl_low),
      .sda_low(m_sda_low));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input string nm, input logic [7:0] e,
         input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] idx,
         input logic [7:0] wd);
      @(posedge hclk);
      htrans <= 2'b10;
      haddr <= {ADDR_HI_ZERO, idx, 2'b00};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {RD_PAD, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      ahb(1'b1, idx, d);
   endtask
   task automatic rdc(input string nm, input logic [7:0] idx,
         input logic [7:0] e, input logic [7:0] m);
      ahb(1'b0, idx, 8'h00);
      check(nm, e, rd & m);
   endtask
   task automatic settle();
      repeat (8) @(posedge hclk);
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         rdc("reset", regs[i], (regs[i] == IDX_DIRECTION) ?
            RST_DIRECTION : RST_ZERO, 8'hff);
      end
      wr(IDX_ADDR_MATCH, 8'ha4);
      wr(IDX_CONTROL, {4'h2, MODE_SLV7_EVT});
      u_mst.start();
      settle();
      rdc("start", IDX_STATUS, 8'h08, 8'h18);
      rdc("flag", IDX_IRQ_FLAGS, 8'h08, 8'h08);
      wr(IDX_IRQ_FLAGS, 8'h00);
      rdc("clear", IDX_IRQ_FLAGS, 8'h00, 8'h08);
      // Write transfer, then a data byte refused while buffer is full
      u_mst.byte_io(8'ha4, 1'b1, q, k);
      check("ack", 8'h00, {7'h00, k});
      settle();
      rdc("status", IDX_STATUS, 8'h01, 8'h05);
      rdc("flag", IDX_IRQ_FLAGS, 8'h08, 8'h08);
      rdc("buffer", IDX_BUFFER, 8'ha4, 8'hff);
      rdc("full", IDX_STATUS, 8'h00, 8'h01);
      wr(IDX_IRQ_FLAGS, 8'h00);
      u_mst.byte_io(8'h5a, 1'b1, q, k);
      check("ack", 8'h00, {7'h00, k});
      wr(IDX_IRQ_FLAGS, 8'h00);
      u_mst.byte_io(8'h96, 1'b1, q, k);
      check("nack", 8'h01, {7'h00, k});
      settle();
      rdc("flag", IDX_IRQ_FLAGS, 8'h08, 8'h08);
      rdc("overflow", IDX_CONTROL, 8'h40, 8'h40);
      rdc("buffer", IDX_BUFFER, 8'h5a, 8'hff);
      u_mst.stop();
      settle();
      rdc("stop", IDX_STATUS, 8'h10, 8'h18);
      // Overflow still set, so the address goes unanswered
      u_mst.start();
      u_mst.byte_io(8'ha4, 1'b1, q, k);
      check("nack", 8'h01, {7'h00, k});
      u_mst.stop();
      wr(IDX_CONTROL, {4'h2, MODE_SLV7});
      rdc("overflow", IDX_CONTROL, 8'h00, 8'h40);
      // Read transfer: clock held until software releases it
      u_mst.start();
      u_mst.byte_io(8'ha5, 1'b1, q, k);
      check("ack", 8'h00, {7'h00, k});
      settle();
      rdc("rw", IDX_STATUS, 8'h04, 8'h04);
      check("hold", 8'h01, {7'h00, scl_oe});
      rdc("buffer", IDX_BUFFER, 8'ha5, 8'hff);
      fork
         u_mst.byte_io(8'hff, 1'b0, q, k);
         begin
            wr(IDX_BUFFER, 8'hc3);
            wr(IDX_CONTROL, {4'h3, MODE_SLV7});
         end
      join
      check("tx", 8'hc3, q);
      fork
         u_mst.byte_io(8'hff, 1'b1, q, k);
         begin
            wr(IDX_BUFFER, 8'h3c);
            wr(IDX_CONTROL, {4'h3, MODE_SLV7});
         end
      join
      check("tx", 8'h3c, q);
      settle();
      rdc("rw", IDX_STATUS, 8'h00, 8'h04);
      u_mst.stop();
      // Ten-bit address: SCL held until the address register is rewritten
      wr(IDX_ADDR_MATCH, 8'hf2);
      wr(IDX_CONTROL, {4'h2, MODE_SLV10_EVT});
      u_mst.start();
      u_mst.byte_io(8'hf2, 1'b1, q, k);
      check("ack", 8'h00, {7'h00, k});
      settle();
      rdc("upd", IDX_STATUS, 8'h03, 8'h07);
      check("hold", 8'h01, {7'h00, scl_oe});
      rdc("buffer", IDX_BUFFER, 8'hf2, 8'hff);
      wr(IDX_ADDR_MATCH, 8'h34);
      rdc("upd", IDX_STATUS, 8'h00, 8'h03);
      check("hold", 8'h00, {7'h00, scl_oe});
      u_mst.byte_io(8'h34, 1'b1, q, k);
      check("ack", 8'h00, {7'h00, k});
      settle();
      rdc("upd", IDX_STATUS, 8'h03, 8'h07);
      wr(IDX_ADDR_MATCH, 8'hf2);
      rdc("buffer", IDX_BUFFER, 8'h34, 8'hff);
      u_mst.stop();
      wr(IDX_CONTROL, 8'h00);
      rdc("off", IDX_STATUS, 8'h00, 8'h18);
      // Firmware master pulls lines through the direction register
      wr(IDX_CONTROL, {4'h2, MODE_FW_MASTER});
      rdc("idle", IDX_STATUS, 8'h00, 8'hd8);
      wr(IDX_DIRECTION, 8'hed);
      settle();
      check("lines", 8'h03, {6'h00, scl_oe, sda_oe});
      wr(IDX_DIRECTION, RST_DIRECTION);
      settle();
      check("lines", 8'h00, {6'h00, scl_oe, sda_oe});
      tally_and_finish();
   end
   // Whole run needs well under this span
   initial begin
      #300000;
      num_errors++;
      tally_and_finish();
   end
endmodule
